//--- logic/mem_mgmt_defines.vh
// Purpose: constants for the memory-management register bank
// Assumes: internal register numbers are word indices, not byte addresses
// Notes: definitions only
`ifndef MEM_MGMT_DEFINES_VH
`define MEM_MGMT_DEFINES_VH
`define LOW_BASE_ADDR 32'h0000_00E0
`define LOW_LEN_ADDR 32'h0000_00E1
`define HIGH_BASE_ADDR 32'h0000_00E2
`define HIGH_LEN_ADDR 32'h0000_00E3
`define SYS_BASE_ADDR 32'h0000_00E4
`define SYS_LEN_ADDR 32'h0000_00E5
`define XLATE_EN_ADDR 32'h0000_00E6
`define PHYS_SEL_ADDR 32'h0000_00E7
`define FAULT_ADDR_ADDR 32'h0000_00E8
`define FAULT_PTE_ADDR 32'h0000_00E9
`define FAULT_STS_ADDR 32'h0000_00EA
`define TB_PAR_ADDR_ADDR 32'h0000_00EC
`define TB_PAR_STS_ADDR 32'h0000_00ED
`define PC_PAR_ADDR_ADDR 32'h0000_00F2
`define PC_PAR_STS_ADDR 32'h0000_00F4
`define PC_CTL_ADDR 32'h0000_00F8
`define TAG_BASE 32'h0180_0000
`define TAG_LAST 32'h0180_1FE0
`define DAP_BASE 32'h01C0_0000
`define DAP_LAST 32'h01C0_1FF8
`define TAG_IDX_LSB 5
`define DAP_IDX_LSB 3
`define BASE_TOP 2'h2
`define VA_MSB 29
`define PA_MSB 31
`define FIELD_LSB 9
`define LEN_MSB 21
`define ZERO_WORD 32'h0000_0000
`define VA_RESET 21'h0
`define PA_RESET 23'h0
`define LEN_RESET 22'h0
`define BIT_RESET 1'h0
`define LOW_ZEROS 9'h0
`define LEN_PAD 10'h0
`define BIT_PAD 31'h0
`define LEN_LSB 0
`define CTL_BIT 0
`endif

//--- logic/memory_mgmt_register_bank.v
// Purpose: memory unit internal processor register bank
// Assumes: one-cycle read data after a read strobe; fault and parity capture from the core
// Notes: cache tag and data-parity arrays are held here as plain storage
`timescale 1ns/1ps
`include "mem_mgmt_defines.vh"

// Overview of operation
// - The low region base keeps a writable page-table virtual address in bits 29:9.
// - The low region length keeps a writable 22-bit longword count, upper bits zero.
// - The high region base keeps a writable page-table virtual address in bits 29:9.
// - The high region length keeps a writable 22-bit longword count, upper bits zero.
// - The system base keeps a writable physical address in bits 31:9, low bits zero.
// - The system length keeps a writable 22-bit longword count, upper bits zero.
// - Bit 0 of the map-enable register turns address translation on or off.
// - Bit 0 of the physical-mode register picks a 32-bit (set) or 30-bit (clear) space.
// - The fault address, fault entry address and fault status registers are read-only.
// - The buffer parity address is read-only at EC and its status is read/write at ED.
// - Cache parity address is read-only, cache parity status and control are read/write.
// - Tag entries sit at 0180_0000..0180_1FE0 and data-parity at 01C0_0000..01C0_1FF8.
module memory_mgmt_register_bank #(
  parameter TAG_DEPTH = 256,
  parameter DAP_DEPTH = 1024
) (
  input wire ref_clk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_hit,
  input wire fault_load,
  input wire [31:0] fault_addr_in,
  input wire [31:0] fault_pte_in,
  input wire [31:0] fault_sts_in,
  input wire tb_par_load,
  input wire [31:0] tb_par_addr_in,
  input wire [31:0] tb_par_sts_in,
  input wire pc_par_load,
  input wire [31:0] pc_par_addr_in,
  input wire [31:0] pc_par_sts_in,
  output reg [31:0] low_region_table_vaddr,
  output reg [21:0] low_region_length_longwords,
  output reg [31:0] high_region_table_vaddr,
  output reg [21:0] high_region_length_longwords,
  output reg [31:0] system_table_paddr,
  output reg [21:0] system_table_length_longwords,
  output reg translation_on,
  output reg wide_phys_space,
  output reg [31:0] primary_cache_ctl
);

  // address bits needed to pick one of depth entries
  function integer index_width;
    input integer depth;
    integer n;
    begin
      index_width = 0;
      for (n = depth - 1; n > 0; n = n >> 1) begin
        index_width = index_width + 1;
      end
    end
  endfunction

  localparam TAG_IDX_W = index_width(TAG_DEPTH);
  localparam DAP_IDX_W = index_width(DAP_DEPTH);

  reg [20:0] low_va;
  reg [20:0] high_va;
  reg [22:0] sys_pa;
  reg [21:0] low_len;
  reg [21:0] high_len;
  reg [21:0] sys_len;
  reg xlate;
  reg wide;
  reg [31:0] fault_address;
  reg [31:0] fault_entry_address;
  reg [31:0] fault_status;
  reg [31:0] xlate_buffer_parity_address;
  reg [31:0] xlate_buffer_parity_status;
  reg [31:0] primary_cache_parity_address;
  reg [31:0] primary_cache_parity_status;
  reg [31:0] pc_ctl;
  reg [31:0] tag_mem [0:TAG_DEPTH-1];
  reg [31:0] dap_mem [0:DAP_DEPTH-1];
  reg [31:0] next_rdata;
  reg next_hit;

  // true when an address lies inside an array window, end points included
  function in_window;
    input [31:0] addr;
    input [31:0] first;
    input [31:0] last;
    begin
      in_window = (addr >= first) && (addr <= last);
    end
  endfunction

  // zero-extend a 22-bit length to a register word
  function [31:0] len_word;
    input [21:0] len;
    begin
      len_word = {`LEN_PAD, len};
    end
  endfunction

  // zero-extend a single control bit to a register word
  function [31:0] bit_word;
    input bit_value;
    begin
      bit_word = {`BIT_PAD, bit_value};
    end
  endfunction

  // fixed bits of the base words are rebuilt here and never stored
  wire [31:0] low_base_word = {`BASE_TOP, low_va, `LOW_ZEROS};
  wire [31:0] high_base_word = {`BASE_TOP, high_va, `LOW_ZEROS};
  wire [31:0] sys_base_word = {sys_pa, `LOW_ZEROS};
  wire tag_sel = in_window(reg_addr, `TAG_BASE, `TAG_LAST);
  wire dap_sel = in_window(reg_addr, `DAP_BASE, `DAP_LAST);
  wire [TAG_IDX_W-1:0] tag_idx = reg_addr[`TAG_IDX_LSB+TAG_IDX_W-1:`TAG_IDX_LSB];
  wire [DAP_IDX_W-1:0] dap_idx = reg_addr[`DAP_IDX_LSB+DAP_IDX_W-1:`DAP_IDX_LSB];

  // one write strobe per writable register
  wire wr_low_base = reg_wr && (reg_addr == `LOW_BASE_ADDR);
  wire wr_low_len = reg_wr && (reg_addr == `LOW_LEN_ADDR);
  wire wr_high_base = reg_wr && (reg_addr == `HIGH_BASE_ADDR);
  wire wr_high_len = reg_wr && (reg_addr == `HIGH_LEN_ADDR);
  wire wr_sys_base = reg_wr && (reg_addr == `SYS_BASE_ADDR);
  wire wr_sys_len = reg_wr && (reg_addr == `SYS_LEN_ADDR);
  wire wr_xlate = reg_wr && (reg_addr == `XLATE_EN_ADDR);
  wire wr_phys = reg_wr && (reg_addr == `PHYS_SEL_ADDR);
  wire wr_tb_sts = reg_wr && (reg_addr == `TB_PAR_STS_ADDR);
  wire wr_pc_sts = reg_wr && (reg_addr == `PC_PAR_STS_ADDR);
  wire wr_pc_ctl = reg_wr && (reg_addr == `PC_CTL_ADDR);
  wire wr_tag = reg_wr && tag_sel;
  wire wr_dap = reg_wr && dap_sel;

  // process region tables
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_va <= `VA_RESET;
      low_len <= `LEN_RESET;
      high_va <= `VA_RESET;
      high_len <= `LEN_RESET;
    end else begin
      if (wr_low_base) begin
        low_va <= reg_wdata[`VA_MSB:`FIELD_LSB];
      end
      if (wr_low_len) begin
        low_len <= reg_wdata[`LEN_MSB:`LEN_LSB];
      end
      if (wr_high_base) begin
        high_va <= reg_wdata[`VA_MSB:`FIELD_LSB];
      end
      if (wr_high_len) begin
        high_len <= reg_wdata[`LEN_MSB:`LEN_LSB];
      end
    end
  end

  // system page table
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_pa <= `PA_RESET;
      sys_len <= `LEN_RESET;
    end else begin
      if (wr_sys_base) begin
        sys_pa <= reg_wdata[`PA_MSB:`FIELD_LSB];
      end
      if (wr_sys_len) begin
        sys_len <= reg_wdata[`LEN_MSB:`LEN_LSB];
      end
    end
  end

  // translation switches and cache control
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xlate <= `BIT_RESET;
      wide <= `BIT_RESET;
      pc_ctl <= `ZERO_WORD;
    end else begin
      if (wr_xlate) begin
        xlate <= reg_wdata[`CTL_BIT];
      end
      if (wr_phys) begin
        wide <= reg_wdata[`CTL_BIT];
      end
      if (wr_pc_ctl) begin
        pc_ctl <= reg_wdata;
      end
    end
  end

  // exception capture from the core; software writes have no path here
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_address <= `ZERO_WORD;
      fault_entry_address <= `ZERO_WORD;
      fault_status <= `ZERO_WORD;
    end else if (fault_load) begin
      fault_address <= fault_addr_in;
      fault_entry_address <= fault_pte_in;
      fault_status <= fault_sts_in;
    end
  end

  // a capture from the core wins over a software write in the same cycle
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      xlate_buffer_parity_address <= `ZERO_WORD;
      xlate_buffer_parity_status <= `ZERO_WORD;
    end else if (tb_par_load) begin
      xlate_buffer_parity_address <= tb_par_addr_in;
      xlate_buffer_parity_status <= tb_par_sts_in;
    end else if (wr_tb_sts) begin
      xlate_buffer_parity_status <= reg_wdata;
    end
  end

  // same priority as above: the capture beats a status write
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      primary_cache_parity_address <= `ZERO_WORD;
      primary_cache_parity_status <= `ZERO_WORD;
    end else if (pc_par_load) begin
      primary_cache_parity_address <= pc_par_addr_in;
      primary_cache_parity_status <= pc_par_sts_in;
    end else if (wr_pc_sts) begin
      primary_cache_parity_status <= reg_wdata;
    end
  end

  // array storage has no reset
  always @(posedge ref_clk) begin
    if (wr_tag) begin
      tag_mem[tag_idx] <= reg_wdata;
    end
    if (wr_dap) begin
      dap_mem[dap_idx] <= reg_wdata;
    end
  end

  always @* begin
    next_rdata = `ZERO_WORD;
    next_hit = 1'b1;
    if (tag_sel) begin
      next_rdata = tag_mem[tag_idx];
    end else if (dap_sel) begin
      next_rdata = dap_mem[dap_idx];
    end else begin
      case (reg_addr)
        `LOW_BASE_ADDR: next_rdata = low_base_word;
        `LOW_LEN_ADDR: next_rdata = len_word(low_len);
        `HIGH_BASE_ADDR: next_rdata = high_base_word;
        `HIGH_LEN_ADDR: next_rdata = len_word(high_len);
        `SYS_BASE_ADDR: next_rdata = sys_base_word;
        `SYS_LEN_ADDR: next_rdata = len_word(sys_len);
        `XLATE_EN_ADDR: next_rdata = bit_word(xlate);
        `PHYS_SEL_ADDR: next_rdata = bit_word(wide);
        `FAULT_ADDR_ADDR: next_rdata = fault_address;
        `FAULT_PTE_ADDR: next_rdata = fault_entry_address;
        `FAULT_STS_ADDR: next_rdata = fault_status;
        `TB_PAR_ADDR_ADDR: next_rdata = xlate_buffer_parity_address;
        `TB_PAR_STS_ADDR: next_rdata = xlate_buffer_parity_status;
        `PC_PAR_ADDR_ADDR: next_rdata = primary_cache_parity_address;
        `PC_PAR_STS_ADDR: next_rdata = primary_cache_parity_status;
        `PC_CTL_ADDR: next_rdata = pc_ctl;
        default: next_hit = 1'b0;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `ZERO_WORD;
      reg_hit <= `BIT_RESET;
      low_region_table_vaddr <= `ZERO_WORD;
      high_region_table_vaddr <= `ZERO_WORD;
      system_table_paddr <= `ZERO_WORD;
      low_region_length_longwords <= `LEN_RESET;
      high_region_length_longwords <= `LEN_RESET;
      system_table_length_longwords <= `LEN_RESET;
      translation_on <= `BIT_RESET;
      wide_phys_space <= `BIT_RESET;
      primary_cache_ctl <= `ZERO_WORD;
    end else begin
      if (reg_rd) begin
        reg_rdata <= next_rdata;
        reg_hit <= next_hit;
      end else begin
        reg_hit <= 1'b0;
      end
      low_region_table_vaddr <= low_base_word;
      high_region_table_vaddr <= high_base_word;
      system_table_paddr <= sys_base_word;
      low_region_length_longwords <= low_len;
      high_region_length_longwords <= high_len;
      system_table_length_longwords <= sys_len;
      translation_on <= xlate;
      wide_phys_space <= wide;
      primary_cache_ctl <= pc_ctl;
    end
  end

endmodule // memory_mgmt_register_bank

//--- verif/memory_mgmt_checker.sv
// Purpose: port assertions for the memory-management register bank
// Assumes: read answer one edge after the strobe, outputs two edges after a write
// Notes: bound to every instance of the bank
`timescale 1ns/1ps
module memory_mgmt_checker (
  input wire ref_clk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire reg_hit,
  input wire [31:0] low_region_table_vaddr,
  input wire [31:0] high_region_table_vaddr,
  input wire [31:0] system_table_paddr,
  input wire translation_on,
  input wire wide_phys_space
);
  reg [31:0] wd1;
  reg [31:0] wd2;
  // write data as it was two edges back, matching the output latency
  always @(posedge ref_clk) begin
    wd1 <= reg_wdata;
    wd2 <= wd1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_base_fixed: assert property ($past(rst_b) |-> low_region_table_vaddr[31:30] == 2'b10
    && low_region_table_vaddr[8:0] == 9'h0 && high_region_table_vaddr[31:30] == 2'b10
    && high_region_table_vaddr[8:0] == 9'h0) else $error("region base fixed bits wrong");
  chk_low_base_write: assert property (reg_wr && reg_addr == 32'h0000_00E0 |-> ##2
    low_region_table_vaddr == {2'b10, wd2[29:9], 9'h0}) else $error("low base not written");
  chk_high_base_write: assert property (reg_wr && reg_addr == 32'h0000_00E2 |-> ##2
    high_region_table_vaddr == {2'b10, wd2[29:9], 9'h0}) else $error("high base not written");
  chk_sys_base_write: assert property (reg_wr && reg_addr == 32'h0000_00E4 |-> ##2
    system_table_paddr == {wd2[31:9], 9'h0}) else $error("system base not written");
  chk_map_enable: assert property (reg_wr && reg_addr == 32'h0000_00E6 |-> ##2
    translation_on == wd2[0]) else $error("map enable not written");
  chk_phys_select: assert property (reg_wr && reg_addr == 32'h0000_00E7 |-> ##2
    wide_phys_space == wd2[0]) else $error("space select not written");
  chk_unmapped_read: assert property (reg_rd && reg_addr == 32'h0000_00EB |=>
    !reg_hit && reg_rdata == 32'h0) else $error("hole answered a read");
  chk_tag_last_hit: assert property (reg_rd && reg_addr == 32'h0180_1FE0 |=> reg_hit)
    else $error("last tag entry missed");
endmodule // memory_mgmt_checker

bind memory_mgmt_register_bank memory_mgmt_checker i_memory_mgmt_checker (
  .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .low_region_table_vaddr(low_region_table_vaddr),
  .high_region_table_vaddr(high_region_table_vaddr),
  .system_table_paddr(system_table_paddr),
  .translation_on(translation_on), .wide_phys_space(wide_phys_space)
);

//--- verif/memory_mgmt_register_bank_bench.sv
// Purpose: self-checking bench for the memory-management register bank
// Assumes: model keyed by register number holds what each read must return
// Notes: read-only places are written too and must keep captured values
`timescale 1ns/1ps
module memory_mgmt_register_bank_bench;
  logic ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  logic fault_load = 0, tb_par_load = 0, pc_par_load = 0;
  logic [31:0] reg_addr = 0, reg_wdata = 0, fault_addr_in = 0, fault_pte_in = 0;
  logic [31:0] fault_sts_in = 0, tb_par_addr_in = 0, tb_par_sts_in = 0;
  logic [31:0] pc_par_addr_in = 0, pc_par_sts_in = 0;
  wire [31:0] reg_rdata, low_region_table_vaddr, high_region_table_vaddr;
  wire [31:0] system_table_paddr, primary_cache_ctl;
  wire [21:0] low_region_length_longwords, high_region_length_longwords;
  wire [21:0] system_table_length_longwords;
  wire reg_hit, translation_on, wide_phys_space;
  integer seed = 50, miscompares = 0, num_checks = 0, cycles = 0, i, k;
  logic [31:0] model [int];
  logic [31:0] addrs [20] = '{32'hE0, 32'hE1, 32'hE2, 32'hE3, 32'hE4, 32'hE5, 32'hE6,
    32'hE7, 32'hE8, 32'hE9, 32'hEA, 32'hEC, 32'hED, 32'hF2, 32'hF4, 32'hF8,
    32'h0180_0000, 32'h0180_1FE0, 32'h01C0_0000, 32'h01C0_1FF8};
  memory_mgmt_register_bank i_memory_mgmt_register_bank (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .fault_load(fault_load), .fault_addr_in(fault_addr_in), .fault_pte_in(fault_pte_in),
    .fault_sts_in(fault_sts_in), .tb_par_load(tb_par_load), .tb_par_addr_in(tb_par_addr_in),
    .tb_par_sts_in(tb_par_sts_in), .pc_par_load(pc_par_load),
    .pc_par_addr_in(pc_par_addr_in), .pc_par_sts_in(pc_par_sts_in),
    .low_region_table_vaddr(low_region_table_vaddr),
    .low_region_length_longwords(low_region_length_longwords),
    .high_region_table_vaddr(high_region_table_vaddr),
    .high_region_length_longwords(high_region_length_longwords),
    .system_table_paddr(system_table_paddr),
    .system_table_length_longwords(system_table_length_longwords),
    .translation_on(translation_on), .wide_phys_space(wide_phys_space),
    .primary_cache_ctl(primary_cache_ctl)
  );
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  function [31:0] masked(input [31:0] a, input [31:0] d);
    case (a)
      32'hE0, 32'hE2: masked = {2'b10, d[29:9], 9'h0};
      32'hE1, 32'hE3, 32'hE5: masked = {10'h0, d[21:0]};
      32'hE4: masked = {d[31:9], 9'h0};
      32'hE6, 32'hE7: masked = {31'h0, d[0]};
      default: masked = d;
    endcase
  endfunction
  task check(input [31:0] seen, input [31:0] want);
    num_checks = num_checks + 1;
    if (seen !== want) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    @(posedge ref_clk) #1;
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr = 0;
    // read-only places keep what the core captured
    if (!(a inside {32'hE8, 32'hE9, 32'hEA, 32'hEC, 32'hF2})) model[a] = masked(a, d);
  endtask
  task rd(input [31:0] a);
    @(posedge ref_clk) #1;
    reg_rd = 1;
    reg_addr = a;
    @(posedge ref_clk) #1;
    reg_rd = 0;
    check(reg_rdata, model.exists(a) ? model[a] : 32'h0);
    check({31'h0, reg_hit}, 32'(model.exists(a)));
  endtask
  task outputs_check;
    check(low_region_table_vaddr, model[32'hE0]);
    check(high_region_table_vaddr, model[32'hE2]);
    check(system_table_paddr, model[32'hE4]);
    check({10'h0, low_region_length_longwords}, model[32'hE1]);
    check({10'h0, high_region_length_longwords}, model[32'hE3]);
    check({10'h0, system_table_length_longwords}, model[32'hE5]);
    check({31'h0, translation_on}, model[32'hE6]);
    check({31'h0, wide_phys_space}, model[32'hE7]);
    check(primary_cache_ctl, model[32'hF8]);
  endtask
  task reset_check;
    for (i = 0; i < 16; i++) begin
      model[addrs[i]] = masked(addrs[i], 32'h0);
      rd(addrs[i]);
    end
    outputs_check;
    $display("reset values test done");
  endtask
  // both parity loads fire in the cycle of a status write; the loads must win
  task load_race(input [31:0] a);
    @(posedge ref_clk) #1;
    {tb_par_sts_in, pc_par_sts_in} = {$random(seed), $random(seed)};
    {tb_par_load, pc_par_load, reg_wr} = 3'h7;
    reg_addr = a;
    reg_wdata = $random(seed);
    @(posedge ref_clk) #1;
    {tb_par_load, pc_par_load, reg_wr} = 3'h0;
    {model[32'hEC], model[32'hED]} = {tb_par_addr_in, tb_par_sts_in};
    {model[32'hF2], model[32'hF4]} = {pc_par_addr_in, pc_par_sts_in};
    rd(a);
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rst_b = 1;
    reset_check;
    @(posedge ref_clk) #1;
    {fault_addr_in, fault_pte_in, fault_sts_in} = {$random(seed), $random(seed), $random(seed)};
    {tb_par_addr_in, tb_par_sts_in} = {$random(seed), $random(seed)};
    {pc_par_addr_in, pc_par_sts_in} = {$random(seed), $random(seed)};
    {fault_load, tb_par_load, pc_par_load} = 3'h7;
    @(posedge ref_clk) #1;
    {fault_load, tb_par_load, pc_par_load} = 3'h0;
    {model[32'hE8], model[32'hE9], model[32'hEA]} = {fault_addr_in, fault_pte_in, fault_sts_in};
    {model[32'hEC], model[32'hED]} = {tb_par_addr_in, tb_par_sts_in};
    {model[32'hF2], model[32'hF4]} = {pc_par_addr_in, pc_par_sts_in};
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 20; i++) wr(addrs[i], $random(seed));
      for (i = 0; i < 20; i++) rd(addrs[i]);
      rd(32'hEB);
      rd(32'h0180_2000);
      outputs_check;
      $display("write and readback pass %0d done", k);
    end
    load_race(32'hED);
    load_race(32'hF4);
    $display("load against write test done");
    @(posedge ref_clk) #1;
    rst_b = 0;
    @(posedge ref_clk) #1;
    rst_b = 1;
    model.delete();
    reset_check;
    print_verdict;
  end
endmodule // memory_mgmt_register_bank_bench
